// file: rtl/timer16_pkg.sv
// Package for the 16-bit waveform timer: register map, fields, mode codes.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
package timer16_pkg;
  localparam logic [7:0] OFF_OUTPUT_MODE = 8'h80;
  localparam logic [7:0] OFF_CLOCK_MODE = 8'h84;
  localparam logic [7:0] OFF_PIN_ENABLE = 8'h88;
  localparam logic [7:0] OFF_COUNTER = 8'h8C;
  localparam logic [7:0] OFF_COMPARE_A = 8'h90;
  localparam logic [7:0] OFF_COMPARE_B = 8'h94;
  localparam logic [7:0] OFF_CAPTURE = 8'h98;
  localparam logic [7:0] OFF_FLAGS = 8'h9C;
  localparam logic [7:0] OFF_PORT_CTRL = 8'hA0;
  localparam int CHAN_A_MODE_LSB = 6;
  localparam int CHAN_B_MODE_LSB = 4;
  localparam int MODE_LO_LSB = 0;
  localparam int MODE_HI_LSB = 3;
  localparam logic [7:0] OUTPUT_MODE_WMASK = 8'hF3;
  localparam logic [7:0] CLOCK_MODE_WMASK = 8'h18;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  typedef enum logic [1:0] {
    KIND_NONPWM = 2'b00,
    KIND_FAST = 2'b01,
    KIND_PHASE = 2'b10,
    KIND_PFC = 2'b11
  } mode_kind_t;
endpackage : timer16_pkg

// file: rtl/timer16_mode_decode.sv
// Decodes the four-bit waveform mode into counting kind, TOP and a reserved-mode flag.
// Pure combinational; the caller supplies the active compare and capture.
module timer16_mode_decode (
  // Mode and TOP sources
  input wire logic [3:0] waveform_mode_sel,
  input wire logic [15:0] compare_value_a,
  input wire logic [15:0] capture_value,
  // Decoded
  output timer16_pkg::mode_kind_t kind,
  output logic [15:0] top,
  output logic reserved_mode
);
  always_comb begin
    kind = timer16_pkg::KIND_NONPWM;
    top = timer16_pkg::TOP_MAX;
    reserved_mode = 1'b0;
    case (waveform_mode_sel)
      4'h0: top = timer16_pkg::TOP_MAX;
      4'h1: begin
        kind = timer16_pkg::KIND_PHASE;
        top = timer16_pkg::TOP_8BIT;
      end
      4'h2: begin
        kind = timer16_pkg::KIND_PHASE;
        top = timer16_pkg::TOP_9BIT;
      end
      4'h3: begin
        kind = timer16_pkg::KIND_PHASE;
        top = timer16_pkg::TOP_10BIT;
      end
      4'h4: top = compare_value_a;
      4'h5: begin
        kind = timer16_pkg::KIND_FAST;
        top = timer16_pkg::TOP_8BIT;
      end
      4'h6: begin
        kind = timer16_pkg::KIND_FAST;
        top = timer16_pkg::TOP_9BIT;
      end
      4'h7: begin
        kind = timer16_pkg::KIND_FAST;
        top = timer16_pkg::TOP_10BIT;
      end
      4'h8: begin
        kind = timer16_pkg::KIND_PFC;
        top = capture_value;
      end
      4'h9: begin
        kind = timer16_pkg::KIND_PFC;
        top = compare_value_a;
      end
      4'hA: begin
        kind = timer16_pkg::KIND_PHASE;
        top = capture_value;
      end
      4'hB: begin
        kind = timer16_pkg::KIND_PHASE;
        top = compare_value_a;
      end
      4'hC: top = capture_value;
      4'hD: reserved_mode = 1'b1;
      4'hE: begin
        kind = timer16_pkg::KIND_FAST;
        top = capture_value;
      end
      4'hF: begin
        kind = timer16_pkg::KIND_FAST;
        top = compare_value_a;
      end
      default: top = timer16_pkg::TOP_MAX;
    endcase
  end
endmodule : timer16_mode_decode

// file: rtl/timer16_waveform.sv
// 16-bit timer/counter with waveform modes and two compare output channels.
// Assumes an AXI4-Lite master on aclk and a timer tick enable from outside.
// Operation
// - Fully synchronous on aclk; the timer tick is a clock enable only.
// - Four-bit mode: low bits in output mode control, high in clock mode.
// - Mode 0 counts to 0xFFFF, immediate compare load, overflow at MAX.
// - Modes 4 and 12 use compare A or capture as TOP, immediate load.
// - Phase correct: fixed or register TOP, load at TOP, overflow at BOTTOM.
// - Fast PWM: fixed or register TOP, load at TOP, overflow at TOP.
// - Modes 8 and 9: capture or compare A TOP, load and overflow at BOTTOM.
// - Connected nonzero channel output mode replaces the port function on its enabled pins.
// - Pin driver enabled whenever the direction bit is set, with or without pin enable.
// - Pin enable 0 or output mode 00 leaves the pin a normal port.
// - Non-PWM: settings 01, 10, 11 toggle, clear, set on match.
// - PWM setting 01: B disconnected; A disconnected unless mode bit 3, then A toggles.
// - Fast PWM: 10 clears on match, sets at TOP; 11 the reverse.
// - Fast PWM: match at TOP ignored by 10 and 11, whatever the upper mode bit; the 01 toggle on A still acts.
// - Dual slope: 10 clears on up match, sets on down match; 11 reverse.
// - Output mode control bits 3:2 read as zero and ignore writes.
// - Dual slope counts zero to TOP and back, reversing at each end.
// - Dual slope holds TOP for exactly one tick before counting down.
//
// Design decision made here: the AXI4-Lite interface to the registers.
module timer16_waveform (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Timer tick enable
  input wire logic timer_tick_enable,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Compare pins, four per channel
  output logic [3:0] chan_a_pin_out,
  output logic [3:0] chan_a_pin_oe_n,
  output logic [3:0] chan_b_pin_out,
  output logic [3:0] chan_b_pin_oe_n
);
  logic [7:0] timer_output_mode_control, timer_clock_mode_control;
  logic [7:0] pin_enable_control, port_dir, port_data;
  logic [15:0] counter_value, capture_value;
  logic [15:0] compare_value_a, compare_value_b;
  logic [15:0] buffer_a, buffer_b;
  logic [2:0] flags;
  logic count_down, wave_a, wave_b;
  wire [3:0] waveform_mode_sel = {timer_clock_mode_control[4:3],
                                  timer_output_mode_control[1:0]};
  wire waveform_mode_bit3 = waveform_mode_sel[3];
  wire [1:0] chan_a_output_mode =
    timer_output_mode_control[timer16_pkg::CHAN_A_MODE_LSB +: 2];
  wire [1:0] chan_b_output_mode =
    timer_output_mode_control[timer16_pkg::CHAN_B_MODE_LSB +: 2];
  timer16_pkg::mode_kind_t kind;
  logic [15:0] top;
  logic reserved_mode;
  timer16_mode_decode u_decode (
    .waveform_mode_sel(waveform_mode_sel),
    .compare_value_a(compare_value_a),
    .capture_value(capture_value),
    .kind(kind),
    .top(top),
    .reserved_mode(reserved_mode)
  );
  wire non_pwm = (kind == timer16_pkg::KIND_NONPWM);
  wire fast = (kind == timer16_pkg::KIND_FAST);
  wire dual = (kind == timer16_pkg::KIND_PHASE) ||
              (kind == timer16_pkg::KIND_PFC);
  wire at_top = (counter_value == top);
  wire at_bottom = (counter_value == timer16_pkg::BOTTOM);
  wire at_max = (counter_value == timer16_pkg::TOP_MAX);
  wire tick = timer_tick_enable && !reserved_mode;
  wire match_a = tick && (counter_value == compare_value_a);
  wire match_b = tick && (counter_value == compare_value_b);
  // Dual slope turns round: up at bottom, down once TOP has been held a tick
  wire turn_down = dual && !count_down && at_top;
  wire turn_up = dual && count_down && at_bottom;
  wire [15:0] next_counter =
    (dual && count_down && !at_bottom) ? counter_value - 16'h0001 :
    (dual && at_top) ? counter_value - 16'h0001 :
    (!dual && at_top) ? timer16_pkg::CNT_RESET :
    counter_value + 16'h0001;
  // Buffered compare loading point per mode family
  wire load_now = non_pwm ? 1'b1 :
                  (kind == timer16_pkg::KIND_PFC) ? (tick && at_bottom) :
                  (tick && at_top);
  wire ovf_event = tick && (non_pwm ? at_max : fast ? at_top :
                   (at_bottom && count_down));
  // AXI4-Lite slave
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire wr_lane0 = wr_fire && w_strb[0];
  wire wr_known = (aw_addr <= timer16_pkg::OFF_PORT_CTRL) &&
                  (aw_addr >= timer16_pkg::OFF_OUTPUT_MODE) &&
                  (aw_addr[1:0] == 2'b00);
  wire rd_known = (s_axi_araddr <= timer16_pkg::OFF_PORT_CTRL) &&
                  (s_axi_araddr >= timer16_pkg::OFF_OUTPUT_MODE) &&
                  (s_axi_araddr[1:0] == 2'b00);
  wire wr_ctl_a = wr_lane0 && aw_addr == timer16_pkg::OFF_OUTPUT_MODE;
  wire wr_ctl_b = wr_lane0 && aw_addr == timer16_pkg::OFF_CLOCK_MODE;
  wire wr_pin_en = wr_lane0 && aw_addr == timer16_pkg::OFF_PIN_ENABLE;
  wire wr_cnt = wr_fire && aw_addr == timer16_pkg::OFF_COUNTER;
  wire wr_cmp_a = wr_fire && aw_addr == timer16_pkg::OFF_COMPARE_A;
  wire wr_cmp_b = wr_fire && aw_addr == timer16_pkg::OFF_COMPARE_B;
  wire wr_cap = wr_fire && aw_addr == timer16_pkg::OFF_CAPTURE;
  wire wr_flags = wr_lane0 && aw_addr == timer16_pkg::OFF_FLAGS;
  wire wr_port = wr_fire && aw_addr == timer16_pkg::OFF_PORT_CTRL;
  wire [15:0] wr_half = {w_strb[1] ? w_data[15:8] : 8'h00,
                         w_strb[0] ? w_data[7:0] : 8'h00};
  wire [15:0] cnt_wdata = {w_strb[1] ? w_data[15:8] : counter_value[15:8],
                           w_strb[0] ? w_data[7:0] : counter_value[7:0]};
  logic [31:0] rd_word;
  always_comb begin
    case (s_axi_araddr)
      timer16_pkg::OFF_OUTPUT_MODE:
        rd_word = {24'h000000, timer_output_mode_control};
      timer16_pkg::OFF_CLOCK_MODE:
        rd_word = {24'h000000, timer_clock_mode_control};
      timer16_pkg::OFF_PIN_ENABLE: rd_word = {24'h000000, pin_enable_control};
      timer16_pkg::OFF_COUNTER: rd_word = {16'h0000, counter_value};
      timer16_pkg::OFF_COMPARE_A: rd_word = {16'h0000, buffer_a};
      timer16_pkg::OFF_COMPARE_B: rd_word = {16'h0000, buffer_b};
      timer16_pkg::OFF_CAPTURE: rd_word = {16'h0000, capture_value};
      timer16_pkg::OFF_FLAGS: rd_word = {29'h0000000, flags};
      timer16_pkg::OFF_PORT_CTRL: rd_word = {16'h0000, port_dir, port_data};
      default: rd_word = 32'h00000000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= timer16_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? timer16_pkg::RESP_OKAY :
                       timer16_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Ready registered so each address or data beat is held only one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= timer16_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) &&
                       !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) &&
                      !s_axi_bvalid;
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? timer16_pkg::RESP_OKAY :
                       timer16_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_output_mode_control <= timer16_pkg::REG_RESET;
      timer_clock_mode_control <= timer16_pkg::REG_RESET;
      pin_enable_control <= timer16_pkg::REG_RESET;
      capture_value <= timer16_pkg::CNT_RESET;
      port_dir <= timer16_pkg::REG_RESET;
      port_data <= timer16_pkg::REG_RESET;
    end else begin
      if (wr_ctl_a)
        timer_output_mode_control <= w_data[7:0] &
                                     timer16_pkg::OUTPUT_MODE_WMASK;
      if (wr_ctl_b)
        timer_clock_mode_control <= w_data[7:0] &
                                    timer16_pkg::CLOCK_MODE_WMASK;
      if (wr_pin_en)
        pin_enable_control <= w_data[7:0];
      if (wr_cap)
        capture_value <= wr_half;
      if (wr_port && w_strb[0])
        port_data <= w_data[7:0];
      if (wr_port && w_strb[1])
        port_dir <= w_data[15:8];
    end
  end
  // Compare buffers and active compare values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buffer_a <= timer16_pkg::CNT_RESET;
      buffer_b <= timer16_pkg::CNT_RESET;
      compare_value_a <= timer16_pkg::CNT_RESET;
      compare_value_b <= timer16_pkg::CNT_RESET;
    end else begin
      if (wr_cmp_a)
        buffer_a <= wr_half;
      if (wr_cmp_b)
        buffer_b <= wr_half;
      if (load_now) begin
        compare_value_a <= wr_cmp_a ? wr_half : buffer_a;
        compare_value_b <= wr_cmp_b ? wr_half : buffer_b;
      end
    end
  end
  // Counter; a software write wins over a tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_value <= timer16_pkg::CNT_RESET;
      count_down <= 1'b0;
    end else if (wr_cnt) begin
      counter_value <= cnt_wdata;
    end else if (tick) begin
      counter_value <= next_counter;
      if (!dual)
        count_down <= 1'b0;
      else if (turn_down)
        count_down <= 1'b1;
      else if (turn_up)
        count_down <= 1'b0;
    end
  end
  // Flags: write one to clear, a set in the same cycle wins
  wire [2:0] flag_set = {match_b, match_a, ovf_event};
  wire [2:0] flag_clr = wr_flags ? w_data[2:0] : 3'b000;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      flags <= 3'b000;
    else
      flags <= (flags & ~flag_clr) | flag_set;
  end
  // Waveform generators for each channel
  function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                     input logic match, input logic is_a,
                                     input logic at_cmp_top);
    logic v;
    v = cur;
    if (non_pwm) begin
      if (match)
        v = (com == timer16_pkg::COM_TOGGLE) ? !cur :
            (com == timer16_pkg::COM_CLEAR) ? 1'b0 :
            (com == timer16_pkg::COM_SET) ? 1'b1 : cur;
    end else if (com == timer16_pkg::COM_TOGGLE) begin
      if (match && is_a && waveform_mode_bit3)
        v = !cur;
    end else if (com[1] && fast) begin
      if (tick && at_top)
        v = !com[0];
      else if (match && !at_cmp_top)
        v = com[0];
    end else if (com[1] && dual && match) begin
      v = count_down ? !com[0] : com[0];
    end
    return v;
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_a <= 1'b0;
      wave_b <= 1'b0;
    end else begin
      wave_a <= wave_next(wave_a, chan_a_output_mode, match_a, 1'b1,
                          compare_value_a == top);
      wave_b <= wave_next(wave_b, chan_b_output_mode, match_b, 1'b0,
                          compare_value_b == top);
    end
  end
  // Channel B in PWM mode with setting 01 is reserved; it stays disconnected
  wire conn_a = (chan_a_output_mode != timer16_pkg::COM_OFF) &&
                (non_pwm || chan_a_output_mode != timer16_pkg::COM_TOGGLE ||
                 waveform_mode_bit3);
  wire conn_b = (chan_b_output_mode != timer16_pkg::COM_OFF) &&
                (non_pwm || chan_b_output_mode != timer16_pkg::COM_TOGGLE);
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_pin
      wire use_a = conn_a && pin_enable_control[i];
      wire use_b = conn_b && pin_enable_control[i + 4];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          chan_a_pin_out[i] <= 1'b0;
          chan_a_pin_oe_n[i] <= 1'b1;
          chan_b_pin_out[i] <= 1'b0;
          chan_b_pin_oe_n[i] <= 1'b1;
        end else begin
          chan_a_pin_out[i] <= use_a ? wave_a : port_data[i];
          chan_a_pin_oe_n[i] <= !(port_dir[i] &&
                                  (pin_enable_control[i] || !use_a));
          chan_b_pin_out[i] <= use_b ? wave_b : port_data[i + 4];
          chan_b_pin_oe_n[i] <= !(port_dir[i + 4] &&
                                  (pin_enable_control[i + 4] || !use_b));
        end
      end
    end
  endgenerate
endmodule : timer16_waveform

// file: dv/timer16_waveform_asserts.sv
// Port-level checker for the 16-bit waveform timer, bound to its top.
// Assumes one clock, aclk, and a synchronous active-low aresetn.
module timer16_waveform_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Tick
  input wire logic timer_tick_enable,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [3:0] chan_a_pin_out,
  input wire logic [3:0] chan_a_pin_oe_n,
  input wire logic [3:0] chan_b_pin_out,
  input wire logic [3:0] chan_b_pin_oe_n
);
  logic rd_om;
  logic rd_bad;
  // Remembers what the pending read targets
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_om <= s_axi_araddr == 8'h80;
      rd_bad <= s_axi_araddr[1:0] != 2'h0 || s_axi_araddr < 8'h80 ||
                s_axi_araddr > 8'hA0;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write response late");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read response late");
  property p_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("write ready while response pending");
  property p_rst_pins;
    $rose(aresetn) |-> chan_a_pin_oe_n == 4'hF && chan_b_pin_oe_n == 4'hF
      && chan_a_pin_out == 4'h0 && chan_b_pin_out == 4'h0;
  endproperty
  a_rst_pins: assert property (p_rst_pins)
    else $error("pins driven out of reset");
  property p_idle_pins;
    (!timer_tick_enable && !s_axi_bvalid) [*3]
      |-> $stable(chan_a_pin_out) && $stable(chan_b_pin_out);
  endproperty
  a_idle_pins: assert property (p_idle_pins)
    else $error("pin moved without tick or write");
  property p_om_rsvd;
    s_axi_rvalid && rd_om |-> s_axi_rdata[3:2] == 2'h0;
  endproperty
  a_om_rsvd: assert property (p_om_rsvd)
    else $error("reserved control bits read nonzero");
  property p_rd_resp;
    s_axi_rvalid |-> s_axi_rresp == (rd_bad ? timer16_pkg::RESP_SLVERR :
                                     timer16_pkg::RESP_OKAY);
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("wrong read response code");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_pin: cover property (!$stable(chan_a_pin_out));
endmodule : timer16_waveform_chk

bind timer16_waveform timer16_waveform_chk u_chk (.aclk, .aresetn,
  .timer_tick_enable, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .chan_a_pin_out, .chan_a_pin_oe_n, .chan_b_pin_out, .chan_b_pin_oe_n);

// file: dv/tb.sv
// Self-checking bench for the waveform timer: AXI4-Lite tasks, mode tests.
// Assumes registered bus answers and pins one edge behind their cause.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic tick = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, prev;
  logic [1:0] bresp, rresp, br, rd_r;
  logic [31:0] rdata, rd_d;
  logic [3:0] a_out, a_oe_n, b_out, b_oe_n;
  int error_cnt = 0;
  int checked = 0;
  int flips;

  always #12.5 aclk = ~aclk;

  timer16_waveform uut (.aclk(aclk), .aresetn(aresetn),
    .timer_tick_enable(tick), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chan_a_pin_out(a_out), .chan_a_pin_oe_n(a_oe_n),
    .chan_b_pin_out(b_out), .chan_b_pin_oe_n(b_oe_n));

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    chk_val({30'h0, g}, {30'h0, e});
  endtask : chk_resp

  task automatic chk_pin(input logic [3:0] g, input logic [3:0] e);
    chk_val({28'h0, g}, {28'h0, e});
  endtask : chk_pin

  task automatic report_and_stop;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Address and data go out together; each is dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      aw_ok = aw_ok | awready;
      w_ok = w_ok | wready;
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    // Late bready makes the slave hold its answer a cycle
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    br = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge aclk);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic pulse(input int n);
    @(posedge aclk);
    tick <= 1'b1;
    repeat (n) @(posedge aclk);
    tick <= 1'b0;
    cyc(2);
  endtask : pulse

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h80);
    chk_val(rd_d, 32'h0);
    wr(8'h80, 32'hFF);
    rd(8'h80);
    chk_val(rd_d, 32'hF3);
    wr(8'h84, 32'hFF);
    rd(8'h84);
    chk_val(rd_d, 32'h18);
    rd(8'h00);
    chk_resp(rd_r, timer16_pkg::RESP_SLVERR);
    wr(8'h02, 32'h1);
    chk_resp(br, timer16_pkg::RESP_SLVERR);
    wr(8'h80, 32'h0);
    wr(8'h84, 32'h0);
    wr(8'hA0, 32'hFFA5);
    cyc(2);
    chk_pin(a_out, 4'h5);
    chk_pin(b_out, 4'hA);
    chk_pin(a_oe_n, 4'h0);
    // Clear-on-match on compare A, toggling channel A
    wr(8'h90, 32'h3);
    wr(8'h84, 32'h08);
    wr(8'h80, 32'h40);
    wr(8'h88, 32'h0F);
    wr(8'hA0, 32'h0FA5);
    cyc(2);
    chk_pin(a_oe_n, 4'h0);
    chk_pin(b_oe_n, 4'hF);
    tick <= 1'b1;
    cyc(8);
    flips = 0;
    prev = a_out[0];
    repeat (40) begin
      @(posedge aclk);
      flips += int'(a_out[0] !== prev);
      prev = a_out[0];
    end
    tick <= 1'b0;
    cyc(2);
    chk_val(32'(flips), 32'hA);
    rd(8'h9C);
    chk_val(rd_d & 32'h2, 32'h2);
    rd(8'h8C);
    chk_val(32'(rd_d > 32'h3), 32'h0);
    // Normal mode wraps at MAX; set on match
    wr(8'h80, 32'hC0);
    wr(8'h84, 32'h0);
    wr(8'h90, 32'hFFFF);
    wr(8'h8C, 32'hFFFE);
    wr(8'h9C, 32'h7);
    pulse(2);
    rd(8'h8C);
    chk_val(rd_d, 32'h0);
    rd(8'h9C);
    chk_val(rd_d & 32'h1, 32'h1);
    chk_pin(a_out, 4'hF);
    // Phase correct 8-bit: turn at TOP, clear on down match
    wr(8'h80, 32'hC1);
    wr(8'h90, 32'hFE);
    wr(8'h8C, 32'hFC);
    pulse(5);
    rd(8'h8C);
    chk_val(rd_d, 32'hFD);
    chk_pin(a_out, 4'h0);
    wr(8'h80, 32'h41);
    cyc(2);
    chk_pin(a_out, 4'h5);
    // Fast PWM 8-bit: set at TOP, clear on match
    wr(8'h84, 32'h08);
    wr(8'h80, 32'h81);
    wr(8'h90, 32'h10);
    wr(8'h8C, 32'hF0);
    wr(8'h9C, 32'h7);
    pulse(21);
    rd(8'h8C);
    chk_val(rd_d, 32'h5);
    rd(8'h9C);
    chk_val(rd_d & 32'h1, 32'h1);
    chk_pin(a_out, 4'hF);
    pulse(12);
    chk_pin(a_out, 4'h0);
    // Phase and frequency correct, TOP from compare A, channel B
    wr(8'h88, 32'hFF);
    wr(8'h84, 32'h10);
    wr(8'h80, 32'h21);
    wr(8'h90, 32'h8);
    wr(8'h94, 32'h6);
    wr(8'h8C, 32'h0);
    wr(8'h9C, 32'h7);
    pulse(11);
    rd(8'h8C);
    chk_val(rd_d, 32'h5);
    chk_pin(b_out, 4'hF);
    pulse(6);
    rd(8'h9C);
    chk_val(rd_d, 32'h7);
    // Reserved mode freezes the counter
    wr(8'h84, 32'h18);
    pulse(3);
    rd(8'h8C);
    chk_val(rd_d, 32'h1);
    report_and_stop();
  end

  // The tests take well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb
